/* src/rsc_defines.vh */
/*
 * Constants for the reset source controller: register offsets, codes,
 * field positions, reset values and delay counts.
 * Assumes a 125 MHz system clock and 32-bit APB register access.
 */
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

// =============================================================
// Register offsets (byte addresses)
`define RSC_OFF_PIN_FUNC 12'h000
`define RSC_OFF_FLAGS 12'h004
`define RSC_OFF_UV_LEVEL 12'h008
`define RSC_OFF_WDT_CTRL 12'h00c
`define RSC_OFF_STATUS 12'h010

// =============================================================
// Reset values and codes
`define RSC_PIN_FUNC_POR 8'h55
`define RSC_PIN_FUNC_IO 8'h55
`define RSC_PIN_FUNC_RES 8'haa
`define RSC_UV_LEVEL_POR 8'h66
`define RSC_UV_L165 8'h66
`define RSC_UV_L190 8'h55
`define RSC_UV_L255 8'h33
`define RSC_UV_L315 8'h99
`define RSC_UV_L380 8'haa
`define RSC_UV_OFF 8'hf0
`define RSC_WDT_CTRL_POR 8'h53
`define RSC_WDT_EN_CODE 5'h0a
`define RSC_WDT_DIS_CODE 5'h15

// =============================================================
// Flag bit positions
`define RSC_FLAG_WDT_CFG 0
`define RSC_FLAG_UV_CFG 1
`define RSC_FLAG_UV 2
`define RSC_FLAG_PIN_CFG 3

// =============================================================
// Timing
`define RSC_CLK_MHZ 125
`define RSC_SRESET_US 16
`define RSC_RSTD_US 16
`define RSC_UVFILT_US 120
`define RSC_SRESET_CYC (`RSC_SRESET_US * `RSC_CLK_MHZ)
`define RSC_RSTD_CYC (`RSC_RSTD_US * `RSC_CLK_MHZ)
`define RSC_UVFILT_CYC (`RSC_UVFILT_US * `RSC_CLK_MHZ)

`endif

/* src/rsc_delay.v */
/*
 * Parameterised delay counter: done rises once run has stood for
 * CYCLES clocks and falls when run drops.
 * Assumes run comes from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module rsc_delay #(
	parameter CYCLES = 16
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// Control
	input wire run_i,
	output reg done_o
);

	reg [23:0] count;

	// =============================================================
	// Counter
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count <= 24'h000000;
			done_o <= 1'b0;
		end else if (!run_i) begin
			count <= 24'h000000;
			done_o <= 1'b0;
		end else if (count >= CYCLES - 1) begin
			done_o <= 1'b1;
		end else begin
			count <= count + 24'h000001;
		end
	end

endmodule // rsc_delay

`default_nettype wire

/* src/rsc_top.v */
/*
 * Reset source controller: combines the reset pin, the pin-function
 * control code, the under-voltage detector and level code, and the
 * watchdog time-out and control code into one device reset, and keeps
 * sticky cause flags for software on APB.
 * Assumes the detector, pin and power mode signals are asynchronous,
 * and the watchdog time-out is a one-cycle pulse on CLK_I.
 */
// The APB slave port and the register addresses are this design's own decisions.
// Summary of operation
// [RULE_01] Pin low forces full reset, PC zero
// [RULE_02] Hold reset while pin stays low
// [RULE_03] Add release delay after pin rises
// [RULE_04] Codes select shared IO or reset pin
// [RULE_05] Bad pin code resets after soft delay
// [RULE_06] Bad pin code sets its flag
// [RULE_07] Resets restore pin code except warm watchdog
// [RULE_08] Upper flag bits zero, software clears only
// [RULE_09] Filtered low supply resets, sets flag
// [RULE_10] Short low supply glitches ignored
// [RULE_11] Decode five levels, one disable code
// [RULE_12] Bad level code resets, restores level
// [RULE_13] Bad level code sets its flag
// [RULE_14] Level kept after real under-voltage reset
// [RULE_15] Level powers up at lowest threshold
// [RULE_16] Under-voltage off in idle or sleep
// [RULE_17] Real low voltage sets sticky flag
// [RULE_18] Normal watchdog timeout equals pin reset
// [RULE_19] Sleep timeout clears PC and SP only
// [RULE_20] Bad watchdog code resets, sets flag
// [RULE_21] Timeout flag set, power-down flag kept
// [RULE_22] Delays are parameterised cycle counters
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defines.vh"

module rsc_top #(
	parameter SRESET_CYC = `RSC_SRESET_CYC,
	parameter RSTD_CYC = `RSC_RSTD_CYC,
	parameter UVFILT_CYC = `RSC_UVFILT_CYC
) (
	// Clock and reset
	input wire CLK_I,
	input wire RST_N_I,
	// APB slave
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [11:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	input wire [3:0] PSTRB_I,
	output reg [31:0] PRDATA_O,
	output reg PREADY_O,
	output reg PSLVERR_O,
	// External sources
	input wire EXT_RESET_PIN_N_I,
	input wire UV_BELOW_1V65_I,
	input wire UV_BELOW_1V90_I,
	input wire UV_BELOW_2V55_I,
	input wire UV_BELOW_3V15_I,
	input wire UV_BELOW_3V80_I,
	input wire LOW_POWER_MODE_I,
	input wire WDT_TIMEOUT_I,
	// Reset outputs
	output reg DEVICE_RESET_N_O,
	output reg PC_SP_CLEAR_O,
	output reg WATCHDOG_TIMEOUT_FLAG_O,
	output reg POWER_DOWN_FLAG_O,
	output reg SHARED_IO_PIN_IS_RESET_O,
	output reg WDT_ENABLE_O,
	output reg [2:0] WDT_PERIOD_SEL_O
);

	localparam ST_RUN = 2'd0;
	localparam ST_HOLD = 2'd1;
	localparam ST_RELEASE = 2'd2;

	localparam CS_NONE = 3'd0;
	localparam CS_PIN = 3'd1;
	localparam CS_UV = 3'd2;
	localparam CS_PIN_CFG = 3'd3;
	localparam CS_UV_CFG = 3'd4;
	localparam CS_WDT_CFG = 3'd5;
	localparam CS_WDT = 3'd6;

	// =============================================================
	// Reset release and input synchronisers
	reg [1:0] rst_sync;
	wire rst_n = rst_sync[1];
	reg [7:0] sync1;
	reg [7:0] sync2;
	wire [7:0] async_in = {2'b00, LOW_POWER_MODE_I, UV_BELOW_3V80_I, UV_BELOW_3V15_I,
		UV_BELOW_2V55_I, UV_BELOW_1V90_I, UV_BELOW_1V65_I};
	wire [7:0] async_all = {async_in[7:1], async_in[0]};
	reg pin1;
	reg pin2;

	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	always @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 8'h00;
			sync2 <= 8'h00;
			pin1 <= 1'b1;
			pin2 <= 1'b1;
		end else begin
			sync1 <= async_all;
			sync2 <= sync1;
			pin1 <= EXT_RESET_PIN_N_I;
			pin2 <= pin1;
		end
	end

	wire low_power = sync2[5];

	// =============================================================
	// Registers
	reg [7:0] pin_func;
	reg [7:0] uv_level;
	reg [7:0] wdt_ctrl;
	reg [3:0] flags;
	reg [1:0] state;
	reg [2:0] cause;
	reg [2:0] last_cause;

	wire apb_acc = PSEL_I && PENABLE_I && PREADY_O;
	wire apb_wr = apb_acc && PWRITE_I && PSTRB_I[0];
	wire wr_pin = apb_wr && (PADDR_I == `RSC_OFF_PIN_FUNC);
	wire wr_flags = apb_wr && (PADDR_I == `RSC_OFF_FLAGS);
	wire wr_uv = apb_wr && (PADDR_I == `RSC_OFF_UV_LEVEL);
	wire wr_wdt = apb_wr && (PADDR_I == `RSC_OFF_WDT_CTRL);
	wire addr_ok = (PADDR_I == `RSC_OFF_PIN_FUNC) || (PADDR_I == `RSC_OFF_FLAGS) ||
		(PADDR_I == `RSC_OFF_UV_LEVEL) || (PADDR_I == `RSC_OFF_WDT_CTRL) ||
		(PADDR_I == `RSC_OFF_STATUS);

	// =============================================================
	// Code checks
	wire pin_is_res = (pin_func == `RSC_PIN_FUNC_RES); // [RULE_04]
	wire pin_bad = !pin_is_res && (pin_func != `RSC_PIN_FUNC_IO); // [RULE_05]
	reg uv_bad;
	reg uv_off;
	reg uv_low;
	always @* begin
		uv_bad = 1'b0;
		uv_off = 1'b0;
		uv_low = 1'b0;
		case (uv_level) // [RULE_11]
			`RSC_UV_L165: uv_low = sync2[0];
			`RSC_UV_L190: uv_low = sync2[1];
			`RSC_UV_L255: uv_low = sync2[2];
			`RSC_UV_L315: uv_low = sync2[3];
			`RSC_UV_L380: uv_low = sync2[4];
			`RSC_UV_OFF: uv_off = 1'b1;
			default: uv_bad = 1'b1;
		endcase
	end
	wire wdt_bad = (wdt_ctrl[7:3] != `RSC_WDT_EN_CODE) &&
		(wdt_ctrl[7:3] != `RSC_WDT_DIS_CODE); // [RULE_20]

	// =============================================================
	// Delay counters
	wire uv_run = uv_low && !uv_off && !low_power && (state == ST_RUN); // [RULE_16]
	wire uv_hit;
	wire pin_sr_hit;
	wire uv_sr_hit;
	wire wdt_sr_hit;
	wire rel_hit;
	wire pin_low = pin_is_res && !pin2; // [RULE_02]
	// A pin reset restores the pin code, so the hold keys on the cause
	wire pin_hold = (cause == CS_PIN) && !pin2; // [RULE_02]
	wire in_run = (state == ST_RUN);
	wire pin_sr_run = pin_bad && in_run;
	wire uv_sr_run = uv_bad && in_run;
	wire wdt_sr_run = wdt_bad && in_run;
	wire rel_run = (state == ST_RELEASE) && !pin_low && !pin_hold; // [RULE_03]

	rsc_delay #(.CYCLES(UVFILT_CYC)) u_uvfilt ( // [RULE_10]
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.run_i(uv_run),
		.done_o(uv_hit)
	);

	rsc_delay #(.CYCLES(SRESET_CYC)) u_pin_sr ( // [RULE_22]
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.run_i(pin_sr_run),
		.done_o(pin_sr_hit)
	);

	rsc_delay #(.CYCLES(SRESET_CYC)) u_uv_sr (
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.run_i(uv_sr_run),
		.done_o(uv_sr_hit)
	);

	rsc_delay #(.CYCLES(SRESET_CYC)) u_wdt_sr (
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.run_i(wdt_sr_run),
		.done_o(wdt_sr_hit)
	);

	rsc_delay #(.CYCLES(RSTD_CYC)) u_release ( // [RULE_03]
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.run_i(rel_run),
		.done_o(rel_hit)
	);

	// =============================================================
	// Reset cause selection, pin first
	reg [2:0] next_cause;
	always @* begin
		next_cause = CS_NONE;
		if (pin_low) begin
			next_cause = CS_PIN; // [RULE_01]
		end else if (uv_hit) begin
			next_cause = CS_UV; // [RULE_09]
		end else if (pin_sr_hit) begin
			next_cause = CS_PIN_CFG;
		end else if (uv_sr_hit) begin
			next_cause = CS_UV_CFG;
		end else if (wdt_sr_hit) begin
			next_cause = CS_WDT_CFG;
		end else if (WDT_TIMEOUT_I && !low_power) begin
			next_cause = CS_WDT; // [RULE_18]
		end
	end

	// =============================================================
	// Sequencer and register file
	always @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_RUN;
			cause <= CS_NONE;
			last_cause <= CS_NONE;
			pin_func <= `RSC_PIN_FUNC_POR;
			uv_level <= `RSC_UV_LEVEL_POR; // [RULE_15]
			wdt_ctrl <= `RSC_WDT_CTRL_POR;
			flags <= 4'h0;
			DEVICE_RESET_N_O <= 1'b0;
			PC_SP_CLEAR_O <= 1'b0;
			WATCHDOG_TIMEOUT_FLAG_O <= 1'b0;
			POWER_DOWN_FLAG_O <= 1'b0;
		end else begin
			PC_SP_CLEAR_O <= 1'b0;
			// Register writes; hardware sets below win over clears
			if (wr_pin) begin
				pin_func <= PWDATA_I[7:0];
			end
			if (wr_uv) begin
				uv_level <= PWDATA_I[7:0];
			end
			if (wr_wdt) begin
				wdt_ctrl <= PWDATA_I[7:0];
			end
			if (wr_flags) begin
				flags <= flags & PWDATA_I[3:0]; // [RULE_08]
			end
			if (WDT_TIMEOUT_I && low_power && state == ST_RUN) begin
				PC_SP_CLEAR_O <= 1'b1; // [RULE_19]
				WATCHDOG_TIMEOUT_FLAG_O <= 1'b1;
				POWER_DOWN_FLAG_O <= 1'b1;
			end
			case (state)
				ST_RUN: begin
					DEVICE_RESET_N_O <= 1'b1;
					if (next_cause != CS_NONE) begin
						state <= ST_HOLD;
						cause <= next_cause;
						last_cause <= next_cause;
						DEVICE_RESET_N_O <= 1'b0;
					end
				end
				ST_HOLD: begin
					DEVICE_RESET_N_O <= 1'b0;
					pin_func <= `RSC_PIN_FUNC_POR; // [RULE_07]
					if (cause != CS_UV) begin
						uv_level <= `RSC_UV_LEVEL_POR; // [RULE_12]
					end else begin
						uv_level <= uv_level; // [RULE_14]
					end
					wdt_ctrl <= `RSC_WDT_CTRL_POR;
					case (cause)
						CS_UV: flags[`RSC_FLAG_UV] <= 1'b1; // [RULE_17]
						CS_PIN_CFG: flags[`RSC_FLAG_PIN_CFG] <= 1'b1; // [RULE_06]
						CS_UV_CFG: flags[`RSC_FLAG_UV_CFG] <= 1'b1; // [RULE_13]
						CS_WDT_CFG: flags[`RSC_FLAG_WDT_CFG] <= 1'b1;
						CS_WDT: WATCHDOG_TIMEOUT_FLAG_O <= 1'b1; // [RULE_21]
						default: ;
					endcase
					state <= ST_RELEASE;
				end
				ST_RELEASE: begin
					DEVICE_RESET_N_O <= 1'b0;
					if (rel_hit) begin
						state <= ST_RUN;
						cause <= CS_NONE;
						DEVICE_RESET_N_O <= 1'b1;
					end
				end
				default: begin
					state <= ST_RUN;
				end
			endcase
		end
	end

	// =============================================================
	// APB answer, one wait state
	always @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			PREADY_O <= 1'b0;
			PRDATA_O <= 32'h00000000;
			PSLVERR_O <= 1'b0;
			SHARED_IO_PIN_IS_RESET_O <= 1'b0;
			WDT_ENABLE_O <= 1'b1;
			WDT_PERIOD_SEL_O <= 3'h3;
		end else begin
			SHARED_IO_PIN_IS_RESET_O <= pin_is_res;
			WDT_ENABLE_O <= (wdt_ctrl[7:3] == `RSC_WDT_EN_CODE);
			WDT_PERIOD_SEL_O <= wdt_ctrl[2:0];
			PREADY_O <= PSEL_I && PENABLE_I && !PREADY_O;
			PSLVERR_O <= PSEL_I && PENABLE_I && !PREADY_O && !addr_ok;
			PRDATA_O <= 32'h00000000;
			if (PSEL_I && PENABLE_I && !PREADY_O && !PWRITE_I) begin
				case (PADDR_I)
					`RSC_OFF_PIN_FUNC: PRDATA_O <= {24'h000000, pin_func};
					`RSC_OFF_FLAGS: PRDATA_O <= {28'h0000000, flags};
					`RSC_OFF_UV_LEVEL: PRDATA_O <= {24'h000000, uv_level};
					`RSC_OFF_WDT_CTRL: PRDATA_O <= {24'h000000, wdt_ctrl};
					`RSC_OFF_STATUS: PRDATA_O <= {26'h0, state, last_cause,
						DEVICE_RESET_N_O};
					default: PRDATA_O <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // rsc_top

`default_nettype wire

/* tb/reset_source_controller_bench.sv */
/* Self-checking bench for rsc_top.
   Assumes short delay counts and an APB slave with one wait state. */
`timescale 1ns/1ps
`default_nettype none
module reset_source_controller_bench;
	localparam int SR = 4;
	localparam int RD = 8;
	localparam int UF = 20;
	logic clk, rst_n, psel, pen, pwr, press, lp, wdt, rdy, err, perr;
	logic dev_n, pcsp, tof, power_down_flag, shr, pin_n, wen;
	logic [2:0] wps;
	logic [11:0] pa;
	logic [31:0] pwd, prd, rd;
	logic [15:0] mv;
	logic [4:0] below;
	logic [7:0] code;
	logic [7:0] lv [5] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'haa};
	logic [15:0] thr [5] = '{16'd1650, 16'd1900, 16'd2550, 16'd3150, 16'd3800};
	int n_errors, check_count, seed, lo, m_flags;
	rsc_top #(.SRESET_CYC(SR), .RSTD_CYC(RD), .UVFILT_CYC(UF)) DUT (.CLK_I(clk), .RST_N_I(rst_n),
		.PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd),
		.PSTRB_I(4'hf), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err),
		.EXT_RESET_PIN_N_I(pin_n), .UV_BELOW_1V65_I(below[0]), .UV_BELOW_1V90_I(below[1]),
		.UV_BELOW_2V55_I(below[2]), .UV_BELOW_3V15_I(below[3]), .UV_BELOW_3V80_I(below[4]),
		.LOW_POWER_MODE_I(lp), .WDT_TIMEOUT_I(wdt), .DEVICE_RESET_N_O(dev_n),
		.PC_SP_CLEAR_O(pcsp), .WATCHDOG_TIMEOUT_FLAG_O(tof), .POWER_DOWN_FLAG_O(power_down_flag),
		.SHARED_IO_PIN_IS_RESET_O(shr), .WDT_ENABLE_O(wen), .WDT_PERIOD_SEL_O(wps));
	rsc_supply_model u_sup (.clk_i(clk), .press_i(press), .mv_i(mv), .pin_n_o(pin_n),
		.below_o(below));
	// ==========================================
	// Checking and bus tasks
	task final_report;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task tmo;
		n_errors++;
		$display("Error %0t: timeout", $time);
		final_report;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (rdy !== 1'b1 && k < 50);
		if (rdy !== 1'b1)
			tmo;
		rd = prd;
		perr = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h0);
		chk(rd, e);
	endtask
	// Waits for a device reset; l is its low time, or -1
	task ev(input int n, output int l);
		l = -1;
		repeat (n) begin
			@(posedge clk);
			if (dev_n === 1'b0)
				break;
		end
		if (dev_n === 1'b0) begin
			mv <= 16'd3300;
			l = 0;
			while (dev_n !== 1'b1 && l < 500) begin
				@(posedge clk);
				l++;
			end
			if (l == 500)
				tmo;
		end
	endtask
	// ==========================================
	// Stimulus
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	initial begin
		{rst_n, psel, pen, pwr, press, lp, wdt} = '0;
		pa = '0;
		pwd = '0;
		mv = 16'd3300;
		n_errors = 0;
		check_count = 0;
		m_flags = 0;
		seed = 77816;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rc(12'h000, 32'h55);
		rc(12'h008, 32'h66);
		rc(12'h00c, 32'h53);
		chk({wen, wps}, 4'hb);
		apb(1'b0, 12'h004, 8'h0);
		chk(rd & 32'hfffffffb, 32'h0);
		apb(1'b0, 12'h0f0, 8'h0);
		chk({rd[30:0], perr}, 32'h1);
		wr(12'h004, 8'h00);
		wr(12'h000, 8'haa);
		repeat (2) @(posedge clk);
		chk(shr, 1'b1);
		press <= 1'b1;
		repeat (12) @(posedge clk);
		chk(dev_n, 1'b0);
		press <= 1'b0;
		ev(3, lo);
		chk(lo >= RD + 4, 1);
		rc(12'h000, 32'h55);
		code = 8'($random(seed));
		if (code == 8'h55 || code == 8'haa)
			code = 8'h3c;
		wr(12'h000, code);
		ev(SR + 20, lo);
		chk(lo > 0, 1);
		m_flags = 8;
		rc(12'h004, m_flags);
		wr(12'h004, 8'hf7);
		m_flags = 0;
		rc(12'h004, m_flags);
		mv <= 16'd1600;
		repeat (UF / 2) @(posedge clk);
		mv <= 16'd3300;
		ev(UF + 10, lo);
		chk(lo, -1);
		for (int i = 0; i < 5; i++) begin
			wr(12'h008, lv[i]);
			mv <= thr[i] - 16'd10;
			ev(UF + 20, lo);
			chk(lo > 0, 1);
			m_flags = m_flags | 4;
			rc(12'h004, m_flags);
			rc(12'h008, lv[i]);
		end
		wr(12'h008, 8'hf0);
		mv <= 16'd1000;
		ev(UF + 20, lo);
		chk(lo, -1);
		lp <= 1'b1;
		wr(12'h008, 8'h66);
		ev(UF + 20, lo);
		chk(lo, -1);
		mv <= 16'd3300;
		lp <= 1'b0;
		code = 8'($random(seed));
		if (code inside {8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0})
			code = 8'h12;
		wr(12'h008, code);
		ev(SR + 20, lo);
		chk(lo > 0, 1);
		m_flags = m_flags | 2;
		rc(12'h004, m_flags);
		rc(12'h008, 32'h66);
		wr(12'h00c, 8'h00);
		ev(SR + 20, lo);
		chk(lo > 0, 1);
		m_flags = m_flags | 1;
		rc(12'h004, m_flags);
		wr(12'h000, 8'haa);
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		ev(10, lo);
		chk(lo >= RD - 1, 1);
		chk({tof, power_down_flag}, 2'b10);
		rc(12'h000, 32'h55);
		rc(12'h010, 32'h0d);
		wr(12'h000, 8'haa);
		lp <= 1'b1;
		repeat (4) @(posedge clk);
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		lo = 0;
		repeat (5) begin
			@(posedge clk);
			lo += (pcsp === 1'b1);
		end
		chk(lo, 1);
		ev(10, lo);
		chk(lo, -1);
		chk({tof, power_down_flag}, 2'b11);
		rc(12'h000, 32'haa);
		wr(12'h008, 8'hf0);
		rst_n <= 1'b0;
		lp <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rc(12'h000, 32'h55);
		rc(12'h008, 32'h66);
		final_report;
	end
endmodule // reset_source_controller_bench
`default_nettype wire

/* tb/rsc_monitor.sv */
/* Port checker for rsc_top.
   Assumes a bind into rsc_top and a bench that keeps PSTRB full. */
`timescale 1ns/1ps
`default_nettype none
module rsc_monitor #(
	parameter RSTD_CYC = 4
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// APB
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	// Sources and results
	input wire logic EXT_RESET_PIN_N_I,
	input wire logic LOW_POWER_MODE_I,
	input wire logic WDT_TIMEOUT_I,
	input wire logic DEVICE_RESET_N_O,
	input wire logic PC_SP_CLEAR_O,
	input wire logic WATCHDOG_TIMEOUT_FLAG_O,
	input wire logic SHARED_IO_PIN_IS_RESET_O
);
	// ==========================================
	// Low time since a running device fell
	int lo;
	logic up;
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			lo <= 0;
			up <= 1'b0;
		end else begin
			lo <= DEVICE_RESET_N_O ? 0 : lo + 1;
			up <= up | DEVICE_RESET_N_O;
		end
	end
	// ==========================================
	// Properties
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	sequence s_press;
		SHARED_IO_PIN_IS_RESET_O && $fell(EXT_RESET_PIN_N_I);
	endsequence
	sequence s_sleep;
		LOW_POWER_MODE_I [*4] ##0 WDT_TIMEOUT_I && DEVICE_RESET_N_O;
	endsequence
	sequence s_wr(logic [11:0] a);
		PREADY_O && PWRITE_I && PADDR_I == a;
	endsequence
	pin_reset_a: assert property (s_press |-> ##[1:5] !DEVICE_RESET_N_O)
		else $error("pin press gave no reset");
	pin_hold_a: assert property (s_press ##1 !EXT_RESET_PIN_N_I [*6] |-> !DEVICE_RESET_N_O)
		else $error("reset left while pin low");
	rel_delay_a: assert property ($rose(DEVICE_RESET_N_O) && up |-> lo >= RSTD_CYC)
		else $error("release delay too short");
	pin_select_a: assert property (s_wr(12'h000) ##0 PWDATA_I[7:0] == 8'haa
		|-> ##[1:2] SHARED_IO_PIN_IS_RESET_O) else $error("reset pin not selected");
	bad_pin_a: assert property (s_wr(12'h000) ##0 !(PWDATA_I[7:0] inside {8'h55, 8'haa})
		|=> DEVICE_RESET_N_O [*2] ##[1:40] !DEVICE_RESET_N_O) else $error("bad code timing");
	flag_upper_a: assert property (PREADY_O && !PWRITE_I && PADDR_I == 12'h004
		|-> PRDATA_O[31:4] == 28'h0) else $error("flag upper bits set");
	wdt_reset_a: assert property (!LOW_POWER_MODE_I [*4] ##0 WDT_TIMEOUT_I && DEVICE_RESET_N_O
		|-> ##[1:4] !DEVICE_RESET_N_O ##[0:3] WATCHDOG_TIMEOUT_FLAG_O) else $error("timeout lost");
	sleep_clear_a: assert property (s_sleep |-> ##[1:4] PC_SP_CLEAR_O)
		else $error("no warm clear");
	sleep_warm_a: assert property (s_sleep |-> DEVICE_RESET_N_O [*6])
		else $error("sleep timeout gave full reset");
endmodule // rsc_monitor
bind rsc_top rsc_monitor #(.RSTD_CYC(RSTD_CYC)) u_mon (.CLK_I, .RST_N_I, .PWRITE_I, .PADDR_I,
	.PWDATA_I, .PRDATA_O, .PREADY_O, .EXT_RESET_PIN_N_I, .LOW_POWER_MODE_I, .WDT_TIMEOUT_I,
	.DEVICE_RESET_N_O, .PC_SP_CLEAR_O, .WATCHDOG_TIMEOUT_FLAG_O, .SHARED_IO_PIN_IS_RESET_O);
`default_nettype wire

/* tb/rsc_supply_model.sv */
/* Reset pin RC network and supply detector model.
   Assumes mv_i in millivolts and a pull-up on the pin. */
`timescale 1ns/1ps
`default_nettype none
module rsc_supply_model (
	// Clock and stimulus
	input wire logic clk_i,
	input wire logic press_i,
	input wire logic [15:0] mv_i,
	// Pin and detector levels
	output logic pin_n_o,
	output logic [4:0] below_o
);
	localparam logic [15:0] THR [5] = '{16'd1650, 16'd1900, 16'd2550, 16'd3150, 16'd3800};
	int rc = 0;
	// ==========================================
	// Pin climbs back slowly after release
	always @(posedge clk_i) rc <= press_i ? 6 : (rc > 0 ? rc - 1 : 0);
	assign pin_n_o = rc == 0 && !press_i;
	for (genvar i = 0; i < 5; i++) begin : g_cmp
		assign below_o[i] = mv_i >= 16'd900 && mv_i < THR[i];
	end
endmodule // rsc_supply_model
`default_nettype wire
